// >>> dv/config_security_access_bench.sv
// Self-checking bench for the configuration and security block.
`timescale 1ns/1ns
module config_security_access_bench;
  import cfg_sec_pkg::*;
  localparam logic [CFG_BYTES-1:0][7:0] DEF = {CFG_BYTES{8'ha5}};
  // Key values are arbitrary; the bench hands its own copy to the design.
  localparam logic [15:0]  KEY_UNSEAL_A = 16'h1111;
  localparam logic [15:0]  KEY_UNSEAL_B = 16'h2222;
  localparam logic [15:0]  KEY_FULL_A   = 16'h3333;
  localparam logic [15:0]  KEY_FULL_B   = 16'h4444;
  logic                     ref_clk, sys_rst, cmd_valid, otp_programmed, shutdown_req;
  logic                     cmd_ready, rsp_valid, otp_wr_en, rom_sel, op_run, op_restart;
  logic                     sig_fail;
  cmd_req_s                 cmd_req;
  cmd_rsp_s                 rsp, r;
  logic [7:0]               otp_addr, otp_rd_data, otp_wr_data, rom_data;
  logic [5:0]               rom_addr;
  logic [CFG_BYTES-1:0][7:0] cfg_out;
  sec_level_e               sec_level;
  logic [7:0]               exp_cfg [CFG_BYTES];
  logic [15:0]              s;
  int                       mismatches, n_tests, restarts;

  config_security_access #(
    .ROM_AW(6), .CFG_DEFAULT(DEF), .KEY_UNSEAL_A(KEY_UNSEAL_A), .KEY_UNSEAL_B(KEY_UNSEAL_B),
    .KEY_FULL_A(KEY_FULL_A), .KEY_FULL_B(KEY_FULL_B)) dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .cmd_req(cmd_req), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .rsp(rsp), .rsp_valid(rsp_valid),
    .otp_programmed(otp_programmed), .otp_addr(otp_addr), .otp_rd_data(otp_rd_data),
    .otp_wr_en(otp_wr_en), .otp_wr_data(otp_wr_data), .rom_sel(rom_sel),
    .rom_addr(rom_addr), .rom_data(rom_data), .shutdown_req(shutdown_req),
    .cfg_out(cfg_out), .op_run(op_run), .op_restart(op_restart),
    .sec_level(sec_level), .sig_fail(sig_fail));

  otp_rom_model #(.AW(6)) mdl (
    .ref_clk(ref_clk), .otp_addr(otp_addr), .otp_wr_en(otp_wr_en),
    .otp_wr_data(otp_wr_data), .otp_rd_data(otp_rd_data), .rom_sel(rom_sel),
    .rom_addr(rom_addr), .rom_data(rom_data));

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk)
  begin
    if (op_restart === 1'b1)
      restarts++;
  end

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_sec(input sec_level_e e);
    chk_byte({6'h0, sec_level}, {6'h0, e});
  endtask

  task automatic chk_den(input logic e);
    chk_byte({7'h0, r.denied}, {7'h0, e});
  endtask

  // A slow operation can hold ready low for a whole ROM scan, hence the generous bound.
  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 300)
    begin
      @(negedge ref_clk);
      n++;
    end
    chk_byte({7'h0, cmd_ready}, 8'h01);
  endtask

  task automatic cmd(input logic w, input logic [6:0] c, input logic [7:0] d);
    wait_ready();
    cmd_req <= '{write: w, code: c, data: d};
    cmd_valid <= 1'b1;
    @(posedge ref_clk);
    // The answer stands for the one cycle after the taking edge only.
    @(negedge ref_clk);
    cmd_valid <= 1'b0;
    chk_byte({7'h0, rsp_valid}, 8'h01);
    r = rsp;
    @(negedge ref_clk);
  endtask

  task automatic sub(input logic [15:0] v);
    cmd(1'b1, CMD_SUB_LO, v[7:0]);
    cmd(1'b1, CMD_SUB_HI, v[15:8]);
  endtask

  task automatic wcfg(input logic [7:0] a, input logic [7:0] d);
    cmd(1'b1, CMD_CFG_ADDR, a);
    cmd(1'b1, CMD_CFG_DATA, d);
    exp_cfg[a[3:0]] = d;
  endtask

  task automatic fill_exp(input logic p);
    for (int i = 0; i < CFG_BYTES; i++)
      exp_cfg[i] = p ? 8'h30 + i[7:0] : DEF[i];
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic t_load;
    wait_ready();
    for (int i = 0; i < CFG_BYTES; i++)
      chk_byte(cfg_out[i], exp_cfg[i]);
    chk_byte({7'h0, op_run}, 8'h01);
    chk_sec(restricted_security_level);
    cmd(1'b0, CMD_STATUS, 8'h00);
    chk_byte(r.data, 8'h10);
  endtask

  task automatic do_reset(input logic p);
    otp_programmed <= p;
    sys_rst <= 1'b1;
    repeat (2) @(negedge ref_clk);
    sys_rst <= 1'b0;
    fill_exp(p);
    t_load();
  endtask

  task automatic t_restricted;
    cmd(1'b1, CMD_CFG_DATA, 8'h99);
    chk_den(1'b1);
    wcfg(8'h02, 8'h77);
    cmd(1'b1, CMD_LIVE_SET, 8'h77);
    chk_den(1'b0);
    cmd(1'b0, CMD_LIVE_SET, 8'h00);
    chk_byte(r.data, 8'h77);
    chk_byte(cfg_out[2], 8'h77);
    sub(SUB_SCR_WR);
    chk_den(1'b1);
    sub(SUB_IROM_SIG);
    chk_den(1'b1);
    sub(SUB_CFG_ENTER);
    chk_den(1'b1);
    chk_sec(restricted_security_level);
    chk_byte({7'h0, op_run}, 8'h01);
  endtask

  task automatic t_keys;
    sub(KEY_UNSEAL_A);
    sub(KEY_FULL_A);
    sub(KEY_UNSEAL_B);
    chk_sec(restricted_security_level);
    sub(KEY_UNSEAL_A);
    sub(KEY_UNSEAL_B);
    chk_sec(intermediate_security_level);
    cmd(1'b1, CMD_CFG_ADDR, 8'h05);
    cmd(1'b0, CMD_CFG_DATA, 8'h00);
    chk_byte(r.data, exp_cfg[5]);
    cmd(1'b1, CMD_CFG_DATA, 8'h12);
    chk_den(1'b1);
    chk_byte(cfg_out[5], exp_cfg[5]);
    wcfg(8'h01, 8'h5b);
    chk_byte(cfg_out[1], 8'h5b);
    sub(SUB_CFG_ENTER);
    chk_den(1'b1);
    sub(KEY_FULL_A);
    sub(KEY_FULL_B);
    chk_sec(unrestricted_security_level);
  endtask

  task automatic t_update;
    sub(SUB_CFG_ENTER);
    chk_den(1'b0);
    chk_byte({7'h0, op_run}, 8'h00);
    cmd(1'b0, CMD_STATUS, 8'h00);
    chk_byte(r.data, 8'h16);
    wcfg(8'h05, 8'hc3);
    chk_byte(cfg_out[5], 8'hc3);
    sub(SUB_SEAL);
    chk_den(1'b1);
    sub(SUB_CFG_EXIT);
    chk_byte(8'(restarts), 8'h01);
    chk_byte({7'h0, op_run}, 8'h01);
    chk_byte(cfg_out[5], 8'hc3);
  endtask

  task automatic t_rom_sig;
    for (int sel = 0; sel < 2; sel++)
    begin
      s = 16'h0000;
      for (int a = 0; a < 64; a++)
        s = {s[14:0], s[15]} ^ {8'h00, (sel == 1) ? 8'(a * 3 + 1) : 8'(a) ^ 8'h5c};
      sub((sel == 1) ? SUB_DROM_SIG : SUB_IROM_SIG);
      chk_den(1'b0);
      cmd(1'b0, 7'h40, 8'h00);
      chk_byte(r.data, s[7:0]);
      cmd(1'b0, 7'h41, 8'h00);
      chk_byte(r.data, s[15:8]);
    end
  endtask

  // Calibration byte 12 is changed on purpose: it must not disturb the signature.
  task automatic t_cfg_sig;
    s = 16'h0000;
    for (int i = 0; i < 10; i++)
      s = {s[14:0], s[15]} ^ {8'h00, exp_cfg[i]};
    sub(SUB_CFG_SIG);
    wait_ready();
    chk_byte({7'h0, sig_fail}, {7'h0, s !== {exp_cfg[11], exp_cfg[10]}});
    sub(SUB_CFG_ENTER);
    wcfg(8'h0a, s[7:0]);
    wcfg(8'h0b, s[15:8]);
    wcfg(8'h0c, 8'hee);
    sub(SUB_CFG_EXIT);
    sub(SUB_CFG_SIG);
    wait_ready();
    chk_byte({7'h0, sig_fail}, 8'h00);
  endtask

  task automatic t_scratch;
    for (int i = 0; i < SCR_BYTES; i++)
      cmd(1'b1, 7'h40 + i[6:0], i[7:0] ^ 8'h96);
    sub(SUB_SCR_WR);
    chk_den(1'b0);
    for (int i = 0; i < SCR_BYTES; i++)
      cmd(1'b1, 7'h40 + i[6:0], 8'h00);
    sub(SUB_SCR_OTP);
    chk_den(1'b0);
    sub(SUB_SEAL);
    chk_sec(restricted_security_level);
    sub(SUB_SCR_RD);
    chk_den(1'b0);
    for (int i = 0; i < SCR_BYTES; i++)
    begin
      cmd(1'b0, 7'h40 + i[6:0], 8'h00);
      chk_byte(r.data, i[7:0] ^ 8'h96);
      chk_byte(mdl.mem[OTP_SCR_BASE + i[7:0]], i[7:0] ^ 8'h96);
    end
  endtask

  task automatic t_shutdown;
    shutdown_req <= 1'b1;
    repeat (2) @(negedge ref_clk);
    chk_byte(cfg_out[2], 8'h00);
    chk_byte({7'h0, op_run}, 8'h00);
    shutdown_req <= 1'b0;
    fill_exp(1'b1);
    t_load();
  endtask

  //////////////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_req = '0;
    otp_programmed = 1'b0;
    shutdown_req = 1'b0;
    do_reset(1'b0);
    do_reset(1'b1);
    t_restricted();
    t_keys();
    t_update();
    t_rom_sig();
    t_cfg_sig();
    t_scratch();
    t_shutdown();
    tally_and_finish();
  end

  // The sequence needs some hundreds of cycles; the 30000-cycle limit means a hang.
  initial
  begin
    #3000000;
    mismatches++;
    tally_and_finish();
  end
endmodule // config_security_access_bench

// >>> dv/otp_rom_model.sv
// Behavioural one-time memory and ROM images on the storage side of the block.
`timescale 1ns/1ns
module otp_rom_model #(
  parameter int AW = 6
) (
  input  wire logic          ref_clk,
  input  wire logic [7:0]    otp_addr,
  input  wire logic          otp_wr_en,
  input  wire logic [7:0]    otp_wr_data,
  output logic [7:0]         otp_rd_data,
  input  wire logic          rom_sel,
  input  wire logic [AW-1:0] rom_addr,
  output logic [7:0]         rom_data
);
  logic [7:0] mem [256];

  // Every byte starts with a distinct pattern so that a wrong load address shows up.
  initial
  begin
    for (int i = 0; i < 256; i++)
      mem[i] = 8'h30 + i[7:0];
  end

  always @(posedge ref_clk)
  begin
    if (otp_wr_en)
      mem[otp_addr] <= otp_wr_data;
  end

  assign otp_rd_data = mem[otp_addr];
  // The images are fixed functions of the address, so every scan must agree.
  assign rom_data = rom_sel ? 8'(rom_addr * 3 + 1) : 8'(rom_addr) ^ 8'h5c;
endmodule // otp_rom_model

// >>> verilog/cfg_sec_pkg.sv
// Shared constants, types and carriers of the configuration and security block.
package cfg_sec_pkg;

  localparam int CFG_BYTES = 16;
  localparam int SCR_BYTES = 32;
  localparam logic [3:0] LIVE_LIMIT     = 4'h4;
  localparam logic [3:0] SIG_STORE_ADDR = 4'ha;
  localparam logic [3:0] CAL_BASE       = 4'hc;
  localparam logic [7:0] OTP_SCR_BASE   = 8'h20;

  localparam logic [6:0] CMD_STATUS   = 7'h00;
  localparam logic [6:0] CMD_CFG_ADDR = 7'h10;
  localparam logic [6:0] CMD_CFG_DATA = 7'h11;
  localparam logic [6:0] CMD_LIVE_SET = 7'h12;
  localparam logic [6:0] CMD_SUB_LO   = 7'h3e;
  localparam logic [6:0] CMD_SUB_HI   = 7'h3f;
  localparam logic [1:0] CMD_BUF_PAGE = 2'h2;

  localparam logic [15:0] SUB_SEAL      = 16'h0101;
  localparam logic [15:0] SUB_CFG_ENTER = 16'h0102;
  localparam logic [15:0] SUB_CFG_EXIT  = 16'h0103;
  localparam logic [15:0] SUB_IROM_SIG  = 16'h0104;
  localparam logic [15:0] SUB_DROM_SIG  = 16'h0105;
  localparam logic [15:0] SUB_CFG_SIG   = 16'h0106;
  localparam logic [15:0] SUB_SCR_RD    = 16'h0107;
  localparam logic [15:0] SUB_SCR_WR    = 16'h0108;
  localparam logic [15:0] SUB_SCR_OTP   = 16'h0109;
  localparam logic [15:0] SUB_CFG_OTP   = 16'h010a;

  typedef enum logic [1:0] {
    restricted_security_level,
    intermediate_security_level,
    unrestricted_security_level
  } sec_level_e;

  typedef enum logic [2:0] {ST_LOAD, ST_OFF, ST_IDLE, ST_ROM_SIG, ST_CFG_SIG, ST_OTP_WR} fsm_e;

  typedef struct packed {
    logic       write;
    logic [6:0] code;
    logic [7:0] data;
  } cmd_req_s;

  typedef struct packed {
    logic       denied;
    logic [7:0] data;
  } cmd_rsp_s;

endpackage

// >>> verilog/config_security_access.sv
// Command interpreter, configuration store and security levels of the monitor.
`timescale 1ns/1ns
// What this block does
// (R1) Each direct command is chosen by a 7-bit code that the block decodes.
// (R2) A direct command starts an action, takes a written value, or returns data.
// (R3) Subcommands go through the same codes and move data in 32-byte blocks.
// (R4) After power-up the stored one-time settings load into the working configuration.
// (R5) Without programmed one-time memory the host rewrites settings after each power cycle.
// (R6) Settings are kept in normal, sleep and lowest retention power modes.
// (R7) Shutdown clears everything; the next power-up reloads defaults or one-time settings.
// (R8) Three security levels limit which settings may be seen or changed.
// (R9) Restricted level reads most things, changes selected settings, refuses data memory writes.
// (R10) Intermediate level adds subcommands and data memory reads and writes; the code takes those writes only below LIVE_LIMIT.
// (R11) Unrestricted level reads and changes everything, including one-time memory programming.
// (R12) Selected settings change while running, without the update state.
// (R13) The update state halts operation; leaving it restarts with new settings.
// (R14) The update state is entered only at the unrestricted level.
// (R15) Each level raise needs its own pair of keys sent as subcommands.
// (R16) Subcommands return signatures over instruction and data ROM.
// (R17) A subcommand checks the static settings signature and flags a mismatch.
// (R18) A 32-byte scratchpad holds manufacturing data and can be burnt into one-time memory.
// (R19) Scratchpad writes need the unrestricted level; reads are allowed at any level.
// (R20) A command not allowed at the current level is ignored and changes nothing but the key stage, which a refused subcommand clears.
module config_security_access #(
  parameter int                                  ROM_AW      = 8,
  parameter logic [cfg_sec_pkg::CFG_BYTES-1:0][7:0] CFG_DEFAULT = '0,
  parameter logic [15:0]                         KEY_UNSEAL_A = 16'h1111,
  parameter logic [15:0]                         KEY_UNSEAL_B = 16'h2222,
  parameter logic [15:0]                         KEY_FULL_A   = 16'h3333,
  parameter logic [15:0]                         KEY_FULL_B   = 16'h4444
) (
  input  wire logic                                 ref_clk,
  input  wire logic                                 sys_rst,
  input  wire cfg_sec_pkg::cmd_req_s                cmd_req,
  input  wire logic                                 cmd_valid,
  output logic                                      cmd_ready,
  output cfg_sec_pkg::cmd_rsp_s                     rsp,
  output logic                                      rsp_valid,
  input  wire logic                                 otp_programmed,
  output logic [7:0]                                otp_addr,
  input  wire logic [7:0]                           otp_rd_data,
  output logic                                      otp_wr_en,
  output logic [7:0]                                otp_wr_data,
  output logic                                      rom_sel,
  output logic [ROM_AW-1:0]                         rom_addr,
  input  wire logic [7:0]                           rom_data,
  input  wire logic                                 shutdown_req,
  output logic [cfg_sec_pkg::CFG_BYTES-1:0][7:0]    cfg_out,
  output logic                                      op_run,
  output logic                                      op_restart,
  output cfg_sec_pkg::sec_level_e                   sec_level,
  output logic                                      sig_fail
);
  import cfg_sec_pkg::*;

  typedef struct packed {
    fsm_e                           st;
    sec_level_e                     sec;
    logic [1:0]                     key_stage;
    logic                           cfg_upd;
    logic                           sig_fail;
    logic                           loaded;
    logic                           op_run;
    logic                           op_restart;
    logic [CFG_BYTES-1:0][7:0]      cfg;
    logic [SCR_BYTES-1:0][7:0]      scr;
    logic [SCR_BYTES-1:0][7:0]      xbuf;
    logic [3:0]                     cfg_addr;
    logic [7:0]                     sub_lo;
    logic [ROM_AW-1:0]              idx;
    logic [15:0]                    sig;
    logic                           src_scr;
    logic                           rom_sel;
    logic [7:0]                     otp_addr;
    logic                           otp_wr_en;
    logic [7:0]                     otp_wr_data;
    cmd_rsp_s                       rsp;
    logic                           rsp_valid;
  } state_s;

  state_s      s_q;
  state_s      s_d;
  logic        deny;
  logic        sub_hit;
  logic [15:0] sub_val;
  logic [7:0]  status;

  // Rotate-and-xor keeps the signature cheap; it catches any single byte fault.
  function automatic logic [15:0] sig_step(input logic [15:0] s, input logic [7:0] b);
    return {s[14:0], s[15]} ^ {8'h00, b};
  endfunction

  assign sub_hit = cmd_valid && cmd_ready && cmd_req.write && (cmd_req.code == CMD_SUB_HI);
  assign sub_val = {cmd_req.data, s_q.sub_lo};
  assign status  = {3'b000, s_q.loaded, s_q.sig_fail, s_q.cfg_upd, s_q.sec};

  ////////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    s_d            = s_q;
    deny           = 1'b0;
    s_d.rsp_valid  = 1'b0;
    s_d.op_restart = 1'b0;
    s_d.otp_wr_en  = 1'b0;
    unique case (s_q.st)
      ST_OFF:
      begin
        s_d.st       = ST_LOAD;
        s_d.idx      = '0;
        s_d.otp_addr = 8'h00;
      end
      ST_LOAD:
      begin
        // Factory defaults stand in when the one-time memory is blank.
        s_d.cfg[s_q.idx[3:0]] = otp_programmed ? otp_rd_data : CFG_DEFAULT[s_q.idx[3:0]]; // R4 R7
        s_d.idx      = s_q.idx + 1'b1;
        s_d.otp_addr = 8'(s_q.idx + 1'b1);
        if (s_q.idx[3:0] == 4'hf)
        begin
          s_d.st     = ST_IDLE;
          s_d.loaded = 1'b1;
        end
      end
      ST_IDLE:
      begin
        if (cmd_valid)
        begin
          s_d.rsp_valid = 1'b1;
          s_d.rsp       = '0;
          if (cmd_req.code == CMD_STATUS) // R1
          begin
            if (cmd_req.write)
              deny = 1'b1;
            else
              s_d.rsp.data = status; // R2
          end
          else if (cmd_req.code == CMD_CFG_ADDR)
          begin
            if (cmd_req.write)
              s_d.cfg_addr = cmd_req.data[3:0]; // R2
            else
              s_d.rsp.data = {4'h0, s_q.cfg_addr};
          end
          else if (cmd_req.code == CMD_CFG_DATA)
          begin
            if (s_q.sec == restricted_security_level)
              deny = 1'b1; // R9 R20
            else if (!cmd_req.write)
              s_d.rsp.data = s_q.cfg[s_q.cfg_addr]; // R10
            else if (s_q.cfg_upd || (s_q.cfg_addr < LIVE_LIMIT))
              s_d.cfg[s_q.cfg_addr] = cmd_req.data; // R10 R13
            else
              deny = 1'b1; // R20
          end
          else if (cmd_req.code == CMD_LIVE_SET)
          begin
            // Selected settings stay reachable at every level while running.
            if (s_q.cfg_addr >= LIVE_LIMIT)
              deny = 1'b1; // R8
            else if (cmd_req.write)
              s_d.cfg[s_q.cfg_addr] = cmd_req.data; // R12 R9
            else
              s_d.rsp.data = s_q.cfg[s_q.cfg_addr];
          end
          else if (cmd_req.code == CMD_SUB_LO)
          begin
            if (cmd_req.write)
              s_d.sub_lo = cmd_req.data; // R3
            else
              deny = 1'b1;
          end
          else if (cmd_req.code[6:5] == CMD_BUF_PAGE)
          begin
            if (cmd_req.write)
              s_d.xbuf[cmd_req.code[4:0]] = cmd_req.data; // R3
            else
              s_d.rsp.data = s_q.xbuf[cmd_req.code[4:0]];
          end
          else if (sub_hit)
          begin
            // Any subcommand other than the expected second key breaks a key pair.
            s_d.key_stage = 2'd0; // R15
            case (sub_val)
              KEY_UNSEAL_A:
                if (s_q.sec == restricted_security_level) s_d.key_stage = 2'd1; // R15
                else deny = 1'b1;
              KEY_UNSEAL_B:
                if (s_q.key_stage == 2'd1) s_d.sec = intermediate_security_level; // R15
                else deny = 1'b1;
              KEY_FULL_A:
                if (s_q.sec == intermediate_security_level) s_d.key_stage = 2'd2; // R15
                else deny = 1'b1;
              KEY_FULL_B:
                if (s_q.key_stage == 2'd2) s_d.sec = unrestricted_security_level; // R15 R11
                else deny = 1'b1;
              SUB_SEAL:
                if (!s_q.cfg_upd) s_d.sec = restricted_security_level; // R8
                else deny = 1'b1;
              SUB_CFG_ENTER:
                if (s_q.sec == unrestricted_security_level) s_d.cfg_upd = 1'b1; // R14
                else deny = 1'b1;
              SUB_CFG_EXIT:
                if (s_q.cfg_upd)
                begin
                  s_d.cfg_upd    = 1'b0; // R13
                  s_d.op_restart = 1'b1; // R13
                end
                else deny = 1'b1;
              SUB_IROM_SIG, SUB_DROM_SIG:
                if (s_q.sec != restricted_security_level)
                begin
                  s_d.st      = ST_ROM_SIG; // R16 R10
                  s_d.rom_sel = (sub_val == SUB_DROM_SIG);
                  s_d.idx     = '0;
                  s_d.sig     = 16'h0000;
                end
                else deny = 1'b1;
              SUB_CFG_SIG:
              begin
                s_d.st  = ST_CFG_SIG; // R17
                s_d.idx = '0;
                s_d.sig = 16'h0000;
              end
              SUB_SCR_RD:
                s_d.xbuf = s_q.scr; // R19 R3
              SUB_SCR_WR:
                if (s_q.sec == unrestricted_security_level) s_d.scr = s_q.xbuf; // R19 R18
                else deny = 1'b1;
              SUB_SCR_OTP, SUB_CFG_OTP:
                if (s_q.sec == unrestricted_security_level)
                begin
                  s_d.st      = ST_OTP_WR; // R11 R18
                  s_d.src_scr = (sub_val == SUB_SCR_OTP);
                  s_d.idx     = '0;
                end
                else deny = 1'b1;
              default:
                deny = 1'b1; // R20
            endcase
          end
          else
            deny = 1'b1; // R20
          s_d.rsp.denied = deny;
        end
      end
      ST_ROM_SIG:
      begin
        s_d.sig = sig_step(s_q.sig, rom_data); // R16
        s_d.idx = s_q.idx + 1'b1;
        if (s_q.idx == '1)
        begin
          s_d.xbuf[0] = s_d.sig[7:0];
          s_d.xbuf[1] = s_d.sig[15:8];
          s_d.st      = ST_IDLE;
        end
      end
      ST_CFG_SIG:
      begin
        // The stored signature and the calibration bytes are left out of the sum.
        if ((s_q.idx[3:0] != SIG_STORE_ADDR) && (s_q.idx[3:0] != SIG_STORE_ADDR + 4'h1))
          s_d.sig = sig_step(s_q.sig, s_q.cfg[s_q.idx[3:0]]); // R17
        s_d.idx = s_q.idx + 1'b1;
        if (s_q.idx[3:0] == CAL_BASE - 4'h1)
        begin
          s_d.sig_fail = (s_d.sig != {s_q.cfg[SIG_STORE_ADDR + 4'h1], s_q.cfg[SIG_STORE_ADDR]}); // R17
          s_d.xbuf[0]  = s_d.sig[7:0];
          s_d.xbuf[1]  = s_d.sig[15:8];
          s_d.st       = ST_IDLE;
        end
      end
      ST_OTP_WR:
      begin
        s_d.otp_wr_en = 1'b1; // R18 R11
        s_d.idx       = s_q.idx + 1'b1;
        if (s_q.src_scr)
        begin
          s_d.otp_addr    = OTP_SCR_BASE + {3'b000, s_q.idx[4:0]};
          s_d.otp_wr_data = s_q.scr[s_q.idx[4:0]];
          if (s_q.idx[4:0] == 5'h1f) s_d.st = ST_IDLE;
        end
        else
        begin
          s_d.otp_addr    = {4'h0, s_q.idx[3:0]};
          s_d.otp_wr_data = s_q.cfg[s_q.idx[3:0]];
          if (s_q.idx[3:0] == 4'hf) s_d.st = ST_IDLE;
        end
      end
    endcase
    // Power modes other than shutdown leave the state untouched.
    s_d.op_run = s_d.loaded && !s_d.cfg_upd; // R13 R6
    if (shutdown_req)
    begin
      s_d    = '0; // R7
      s_d.st = ST_OFF;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (sys_rst)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign cmd_ready   = (s_q.st == ST_IDLE);
  assign rsp         = s_q.rsp;
  assign rsp_valid   = s_q.rsp_valid;
  assign otp_addr    = s_q.otp_addr;
  assign otp_wr_en   = s_q.otp_wr_en;
  assign otp_wr_data = s_q.otp_wr_data;
  assign rom_sel     = s_q.rom_sel;
  assign rom_addr    = s_q.idx;
  assign cfg_out     = s_q.cfg;
  assign op_run      = s_q.op_run;
  assign op_restart  = s_q.op_restart;
  assign sec_level   = s_q.sec;
  assign sig_fail    = s_q.sig_fail;

  ////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_rsp_follows;
    cmd_valid && cmd_ready |=> rsp_valid;
  endproperty
  a_rsp_follows: assert property (p_rsp_follows) else $error("No answer to command."); // R1

  property p_addr_set;
    cmd_valid && cmd_ready && cmd_req.write && cmd_req.code == CMD_CFG_ADDR
      |=> s_q.cfg_addr == $past(cmd_req.data[3:0]);
  endproperty
  a_addr_set: assert property (p_addr_set) else $error("Address not stored."); // R2

  property p_scr_block;
    sub_hit && sub_val == SUB_SCR_RD |=> s_q.xbuf == $past(s_q.scr);
  endproperty
  a_scr_block: assert property (p_scr_block) else $error("Scratch block not copied."); // R3

  property p_restr_dm;
    cmd_valid && cmd_ready && cmd_req.write && cmd_req.code == CMD_CFG_DATA
      && sec_level == restricted_security_level |=> rsp.denied && $stable(cfg_out);
  endproperty
  a_restr_dm: assert property (p_restr_dm) else $error("Data memory write at restricted."); // R9

  property p_unseal_rd;
    cmd_valid && cmd_ready && !cmd_req.write && cmd_req.code == CMD_CFG_DATA
      && sec_level != restricted_security_level && !shutdown_req
      |=> !rsp.denied && rsp.data == cfg_out[s_q.cfg_addr];
  endproperty
  a_unseal_rd: assert property (p_unseal_rd) else $error("Data memory read refused."); // R10

  property p_cfg_entry;
    $rose(s_q.cfg_upd) |-> $past(sec_level) == unrestricted_security_level;
  endproperty
  a_cfg_entry: assert property (p_cfg_entry) else $error("Update state without full access."); // R14

  property p_halt;
    s_q.cfg_upd |-> !op_run;
  endproperty
  a_halt: assert property (p_halt) else $error("Running during update state."); // R13

  property p_restart;
    $fell(s_q.cfg_upd) && !$past(shutdown_req) |-> op_restart ##1 op_run;
  endproperty
  a_restart: assert property (p_restart) else $error("No restart after update."); // R13

  property p_key_unseal;
    sec_level == intermediate_security_level && $past(sec_level) == restricted_security_level
      |-> $past(sub_hit) && $past(sub_val) == KEY_UNSEAL_B && $past(s_q.key_stage) == 2'd1;
  endproperty
  a_key_unseal: assert property (p_key_unseal) else $error("Level raised without keys."); // R15

  property p_scr_wr;
    sub_hit && sub_val == SUB_SCR_WR && sec_level != unrestricted_security_level
      && !shutdown_req |=> rsp.denied && $stable(s_q.scr);
  endproperty
  a_scr_wr: assert property (p_scr_wr) else $error("Scratch write below full access."); // R19

  property p_shutdown;
    shutdown_req |=> sec_level == restricted_security_level && cfg_out == '0 && !op_run;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("Shutdown did not clear state."); // R7

  property p_denied_quiet;
    rsp_valid && rsp.denied && !$past(shutdown_req) |-> $stable(cfg_out) && $stable(sec_level);
  endproperty
  a_denied_quiet: assert property (p_denied_quiet) else $error("Refused command changed state."); // R20

  c_full_access: cover property ($rose(sec_level == unrestricted_security_level));
  c_update_cycle: cover property ($fell(s_q.cfg_upd) ##1 op_run);
  c_sig_fail: cover property ($rose(sig_fail));
  c_otp_burn: cover property (otp_wr_en && otp_addr == OTP_SCR_BASE + 8'h1f);

endmodule // config_security_access
